/* File: tb/coeff_regs_props.sv */
/*
 * concurrent checks on the coefficient bank's apb answers and tap outputs.
 * assumes: bound to the bank's top module, one clock, sync reset high.
 */
module coeff_regs_props (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // apb side
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [15:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    input  wire logic        pready_o,
    input  wire logic [31:0] prdata_o,
    input  wire logic        pslverr_o,
    // filter side
    input  wire logic        dual_mode_o,
    input  wire logic [11:0] tap1_coeff_o,
    input  wire logic [11:0] tap6_coeff_o,
    input  wire logic [17:0] center_coeff_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] wd_q;  // write data of the previous cycle
    wire wr = psel_i & penable_i & pwrite_i & pready_o & ~pslverr_o & (pstrb_i[2:0] == 3'h7);
    wire rd = psel_i & penable_i & ~pwrite_i & pready_o & ~pslverr_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // keep write data for the cycle after the write edge
    always_ff @(posedge clk_i) begin
        wd_q <= pwdata_i;
    end
    chk_tap1_write: assert property (wr && dual_mode_o && paddr_i == 16'h1120 |=>
        tap1_coeff_o == wd_q[11:0]) else $error("tap one output mismatch");
    chk_center_write: assert property (wr && dual_mode_o && paddr_i == 16'h1140 |=>
        center_coeff_o == wd_q[17:0]) else $error("centre output mismatch");
    chk_tap6_write: assert property (wr && dual_mode_o && paddr_i == 16'h114c |=>
        tap6_coeff_o == wd_q[11:0]) else $error("tap six output mismatch");
    chk_mode_enable: assert property (wr && paddr_i == 16'h1180 && pwdata_i[0] |=>
        dual_mode_o) else $error("dual mode not entered");
    chk_outer_msb: assert property (rd && paddr_i != 16'h1140 && paddr_i != 16'h1180 |->
        !prdata_o[11]) else $error("outer msb read back set");
    chk_center_msb: assert property (rd && paddr_i == 16'h1140 |->
        !prdata_o[17]) else $error("centre msb read back set");
    chk_reset_clear: assert property ($fell(reset_i) |->
        !dual_mode_o && tap1_coeff_o == 12'h0 && center_coeff_o == 18'h0)
        else $error("outputs not cleared by reset");
    chk_single_zero: assert property (!dual_mode_o |->
        {tap1_coeff_o, tap6_coeff_o, center_coeff_o} == 42'h0) else $error("single mode leak");
    chk_coeff_hold: assert property (dual_mode_o && !(psel_i && pwrite_i) |=>
        $stable(tap1_coeff_o) && $stable(center_coeff_o)) else $error("output moved");
    cover property (wr && dual_mode_o && paddr_i == 16'h1140);
    cover property (rd && paddr_i == 16'h1140);
    cover property (pready_o && pslverr_o);
endmodule // coeff_regs_props

/* File: tb/testbench.sv */
/*
 * self-checking bench for the coefficient bank: drives apb directly.
 * assumes: one write cycle has no wait, read waits until pready.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, dual_mode_o;
    logic [15:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, r;
    logic [3:0]  pstrb_i;
    logic        e;
    logic [11:0] t1, t2, t3, t4, t6, t7, t8, t9;
    logic [17:0] tc;
    logic [17:0] outs [9];  // tap outputs in address order
    int          bad_count, num_checks;
    // byte addresses of taps one to nine, then the mode register
    localparam logic [15:0] ADDR [10] = '{16'h1120, 16'h1128, 16'h1130, 16'h1138, 16'h1140,
        16'h114c, 16'h1154, 16'h115c, 16'h1164, 16'h1180};
    chan_b_fir_coeff_regs chan_b_fir_coeff_regs_i (.clk_i(clk_i), .reset_i(reset_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .pready_o(pready_o), .prdata_o(prdata_o),
        .pslverr_o(pslverr_o), .dual_mode_o(dual_mode_o), .tap1_coeff_o(t1),
        .tap2_coeff_o(t2), .tap3_coeff_o(t3), .tap4_coeff_o(t4), .center_coeff_o(tc),
        .tap6_coeff_o(t6), .tap7_coeff_o(t7), .tap8_coeff_o(t8), .tap9_coeff_o(t9));
    always_comb outs = '{{6'h0, t1}, {6'h0, t2}, {6'h0, t3}, {6'h0, t4}, tc,
        {6'h0, t6}, {6'h0, t7}, {6'h0, t8}, {6'h0, t9}};
    // free running clock, 8 ns period
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        psel_i <= 1'b1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // apply reset for twelve cycles
    task automatic do_reset;
        reset_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // every register reads zero after reset; in dual mode every output is zero too
    task automatic t_zero;
        for (int i = 0; i < 10; i++) begin
            apb(1'b0, ADDR[i], 32'h0);
            chk(r, 32'h0);
        end
        apb(1'b1, ADDR[9], 32'h1);
        chk(dual_mode_o, 1'b1);
        for (int i = 0; i < 9; i++) chk(outs[i], 18'h0);
        apb(1'b1, ADDR[9], 32'h0);
        chk(dual_mode_o, 1'b0);
    endtask
    // write all taps, msb set; outputs only appear in dual mode
    task automatic t_taps;
        for (int i = 0; i < 9; i++) apb(1'b1, ADDR[i], 32'hffff_f800 + i);
        for (int i = 0; i < 9; i++) chk(outs[i], 18'h0);
        apb(1'b1, ADDR[9], 32'h1);
        for (int i = 0; i < 9; i++) begin
            chk(outs[i], (i == 4) ? 18'h3f804 : 18'h800 + i);
            apb(1'b0, ADDR[i], 32'h0);
            chk(r, (i == 4) ? 32'h00fd_f804 : 32'h0000_f000 + i);
        end
    endtask
    // unmapped and misaligned places refuse and leave taps alone
    task automatic t_bad;
        apb(1'b1, 16'h1124, 32'h0);
        chk(e, 1'b1);
        apb(1'b1, 16'h1122, 32'h0);
        chk(e, 1'b1);
        apb(1'b0, 16'h1124, 32'h0);
        chk(e, 1'b1);
        chk(r, 32'h0);
        chk(outs[0], 18'h800);
    endtask
    // live updates in dual mode, full and partial byte strobes
    task automatic t_live;
        apb(1'b1, ADDR[0], 32'h0000_0123);
        chk(outs[0], 18'h123);
        apb(1'b1, ADDR[4], 32'h0002_1234);
        chk(outs[4], 18'h21234);
        apb(1'b1, ADDR[5], 32'h0000_0a5c);
        chk(outs[5], 18'ha5c);
        pstrb_i <= 4'h1;
        apb(1'b1, ADDR[5], 32'h0000_0b37);
        pstrb_i <= 4'hf;
        chk(outs[5], 18'h037);
    endtask
    // print counts and verdict, then stop
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // cut a hang short
    initial begin
        repeat (5000) @(posedge clk_i);
        bad_count++;
        wrap_up();
    end
    // main sequence
    initial begin
        {reset_i, psel_i, penable_i, pwrite_i} = 4'h8;
        paddr_i = 16'h0;
        pwdata_i = 32'h0;
        pstrb_i = 4'hf;
        do_reset();
        t_zero();
        t_taps();
        t_bad();
        t_live();
        do_reset();
        t_zero();
        wrap_up();
    end
endmodule // testbench
bind chan_b_fir_coeff_regs coeff_regs_props coeff_regs_props_i (.clk_i(clk_i),
    .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .pready_o(pready_o),
    .prdata_o(prdata_o), .pslverr_o(pslverr_o), .dual_mode_o(dual_mode_o),
    .tap1_coeff_o(tap1_coeff_o), .tap6_coeff_o(tap6_coeff_o),
    .center_coeff_o(center_coeff_o));

/* File: verilog/chan_b_coeff_map.vh */
/*
 * register offsets, field widths and reset values for the second-channel
 * equalizer filter coefficient bank.
 * assumes: included by bare name from the bank and its storage module.
 */
`ifndef CHAN_B_COEFF_MAP_VH
`define CHAN_B_COEFF_MAP_VH

// register indices on the bus (byte address = 4 * index)
`define TAP1_IDX        12'h448
`define TAP2_IDX        12'h44a
`define TAP3_IDX        12'h44c
`define TAP4_IDX        12'h44e
`define CENTER_IDX      12'h450
`define TAP6_IDX        12'h453
`define TAP7_IDX        12'h455
`define TAP8_IDX        12'h457
`define TAP9_IDX        12'h459
// mode control register of our own
`define MODE_IDX        12'h460

// field widths
`define OUTER_W         12
`define CENTER_W        18
`define OUTER_REG_W     16
`define CENTER_REG_W    24
`define NUM_TAPS        9
`define SLOT_W          4
`define CENTER_SLOT     4'h4
`define NO_SLOT         4'hf

// reset value of every coefficient register
`define COEFF_RESET     24'h000000
`define MODE_RESET      1'h0

`endif

/* File: verilog/chan_b_fir_coeff_regs.v */
/*
 * apb register bank for the second channel's nine-tap equalizer filter
 * coefficients, with coefficient outputs toward the filter datapath.
 * writes complete with no wait state, reads with exactly one; unmapped or
 * misaligned addresses answer with pslverr and leave the store untouched.
 * assumes: a standard apb master, one clock, synchronous active-high reset;
 * the filter arithmetic lives elsewhere.
 */
// The APB register port was left to the implementer.
`include "chan_b_coeff_map.vh"

// Function
// - outer taps: 12-bit signed, low bits
// - taps one to four in address order
// - fifth register: 18-bit signed centre tap
// - readback of coefficient msb is zero
// - all registers reset to zero
// - coefficients drive filter in dual-channel mode
// - taps six to nine follow centre tap
// - single-channel mode ignores these coefficients
module chan_b_fir_coeff_regs (
    // clock and reset
    input  wire                    clk_i,
    input  wire                    reset_i,
    // apb slave
    input  wire                    psel_i,
    input  wire                    penable_i,
    input  wire                    pwrite_i,
    input  wire [15:0]             paddr_i,
    input  wire [31:0]             pwdata_i,
    input  wire [3:0]              pstrb_i,
    output wire                    pready_o,
    output reg  [31:0]             prdata_o,
    output wire                    pslverr_o,
    // filter datapath
    output wire                    dual_mode_o,
    output reg  [`OUTER_W-1:0]     tap1_coeff_o,
    output reg  [`OUTER_W-1:0]     tap2_coeff_o,
    output reg  [`OUTER_W-1:0]     tap3_coeff_o,
    output reg  [`OUTER_W-1:0]     tap4_coeff_o,
    output reg  [`CENTER_W-1:0]    center_coeff_o,
    output reg  [`OUTER_W-1:0]     tap6_coeff_o,
    output reg  [`OUTER_W-1:0]     tap7_coeff_o,
    output reg  [`OUTER_W-1:0]     tap8_coeff_o,
    output reg  [`OUTER_W-1:0]     tap9_coeff_o
);

    // access phase states
    localparam ST_IDLE = 1'b0;  // setup, idle or first access cycle
    localparam ST_READ = 1'b1;  // read data held in prdata_o, pready high

    reg                          state;       // apb read sequencer
    reg                          next_state;  // next sequencer state
    reg                          dual_mode;   // mode control bit
    wire [`SLOT_W-1:0]           slot;        // decoded slot of paddr
    wire                         is_mode;     // paddr hits mode register
    wire                         mapped;      // paddr hits any register
    wire                         access;      // access phase in progress
    wire                         wr_fire;     // write completes this edge
    wire [`CENTER_REG_W-1:0]     rd_word;     // registered store output
    wire [`NUM_TAPS*`CENTER_REG_W-1:0] words; // all stored words
    wire [`CENTER_REG_W-1:0]     next_word;   // masked write data

    // map a word-aligned byte address onto a store slot, address order
    function [`SLOT_W-1:0] decode_slot;
        input [15:0] addr;
        begin
            if (addr[1:0] != 2'h0) begin
                // misaligned byte address never hits a register
                decode_slot = `NO_SLOT;
            end else begin
                // index lookup, in address order
                case (addr[13:2])
                    `TAP1_IDX:   decode_slot = 4'h0;
                    `TAP2_IDX:   decode_slot = 4'h1;
                    `TAP3_IDX:   decode_slot = 4'h2;
                    `TAP4_IDX:   decode_slot = 4'h3;
                    `CENTER_IDX: decode_slot = `CENTER_SLOT;
                    `TAP6_IDX:   decode_slot = 4'h5;
                    `TAP7_IDX:   decode_slot = 4'h6;
                    `TAP8_IDX:   decode_slot = 4'h7;
                    `TAP9_IDX:   decode_slot = 4'h8;
                    default:     decode_slot = `NO_SLOT;
                endcase
                // address bits above the index must be zero too
                if (addr[15:14] != 2'h0) begin
                    decode_slot = `NO_SLOT;
                end
            end
        end
    endfunction

    // width of the register at a slot: 24 for centre, 16 otherwise
    function [`CENTER_REG_W-1:0] reg_mask;
        input [`SLOT_W-1:0] s;
        begin
            if (s == `CENTER_SLOT) begin
                // centre register: 24 bits wide
                reg_mask = {`CENTER_REG_W{1'b1}};
            end else begin
                // outer registers: 16 bits wide
                reg_mask = {{(`CENTER_REG_W-`OUTER_REG_W){1'b0}}, {`OUTER_REG_W{1'b1}}};
            end
        end
    endfunction

    // readback image: coefficient msb forced to zero
    function [`CENTER_REG_W-1:0] read_image;
        input [`SLOT_W-1:0]        s;
        input [`CENTER_REG_W-1:0]  w;
        begin
            // keep only the bits the register holds
            read_image = w & reg_mask(s);
            if (s == `CENTER_SLOT) begin
                read_image[`CENTER_W-1] = 1'b0;
            end else begin
                read_image[`OUTER_W-1] = 1'b0;
            end
        end
    endfunction

    assign slot      = decode_slot(paddr_i);
    // the mode register lives outside the store, so it is decoded apart
    assign is_mode   = (paddr_i[1:0] == 2'h0) && (paddr_i[15:2] == {2'h0, `MODE_IDX});
    assign mapped    = (slot != `NO_SLOT) || is_mode;
    // access phase: second and later cycles of a transfer
    assign access    = psel_i && penable_i;
    // writes finish in the first access cycle; reads wait one cycle for the store
    assign pready_o  = access && (pwrite_i || (state == ST_READ));
    // the error flag only rises with ready, never while a read still waits
    assign pslverr_o = pready_o && !mapped;
    assign wr_fire   = access && pwrite_i && (slot != `NO_SLOT);

    // byte strobes merge with zero; reserved bits stored as written (r/w)
    // lane 3 is ignored: no register is wider than 24 bits
    assign next_word = {pstrb_i[2] ? pwdata_i[23:16] : 8'h00,
                        pstrb_i[1] ? pwdata_i[15:8]  : 8'h00,
                        pstrb_i[0] ? pwdata_i[7:0]   : 8'h00} & reg_mask(slot);

    // coefficient storage with registered read data; the read port follows
    // paddr every cycle, so the word addressed in the setup cycle is ready
    // one edge later, in the first access cycle
    coeff_store u_store (
        .clk_i     (clk_i),
        .reset_i   (reset_i),
        .wr_en_i   (wr_fire),
        .wr_slot_i (slot),
        .wr_data_i (next_word),
        .rd_slot_i (slot),
        .rd_data_o (rd_word),
        .all_o     (words)
    );

    // read sequencer: one wait state on every read; a write never leaves
    // idle, since it completes in its first access cycle
    always @* begin
        case (state)
            ST_IDLE: next_state = (access && !pwrite_i) ? ST_READ : ST_IDLE;
            ST_READ: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // sequencer, mode register and read data register
    always @(posedge clk_i) begin
        if (reset_i) begin
            // everything back to its idle value
            state     <= ST_IDLE;
            dual_mode <= `MODE_RESET;
            prdata_o  <= 32'h00000000;
        end else begin
            state     <= next_state;
            // mode bit written at completion of its access
            if (access && pwrite_i && is_mode && pstrb_i[0]) begin
                dual_mode <= pwdata_i[0];
            end
            // read data captured at the end of the first access cycle, so it stands
            // in the cycle after the wait state, together with pready
            if (access && !pwrite_i && (state == ST_IDLE)) begin
                if (is_mode) begin
                    // mode register: bit 0 only
                    prdata_o <= {31'h00000000, dual_mode};
                end else if (slot != `NO_SLOT) begin
                    // coefficient word from the store, msb masked
                    prdata_o <= {8'h00, read_image(slot, rd_word)};
                end else begin
                    // unmapped address reads as zero
                    prdata_o <= 32'h00000000;
                end
            end
        end
    end

    // mode bit toward the filter datapath: 1 selects dual-channel use
    assign dual_mode_o = dual_mode;

    // coefficients to datapath, zeroed outside dual-channel mode
    // the mask keeps a stale set from reaching the filter in single mode
    always @* begin
        if (dual_mode) begin
            // dual-channel mode: stored low bits, sign bit included
            tap1_coeff_o   = words[0*`CENTER_REG_W +: `OUTER_W];
            tap2_coeff_o   = words[1*`CENTER_REG_W +: `OUTER_W];
            tap3_coeff_o   = words[2*`CENTER_REG_W +: `OUTER_W];
            tap4_coeff_o   = words[3*`CENTER_REG_W +: `OUTER_W];
            center_coeff_o = words[4*`CENTER_REG_W +: `CENTER_W];
            tap6_coeff_o   = words[5*`CENTER_REG_W +: `OUTER_W];
            tap7_coeff_o   = words[6*`CENTER_REG_W +: `OUTER_W];
            tap8_coeff_o   = words[7*`CENTER_REG_W +: `OUTER_W];
            tap9_coeff_o   = words[8*`CENTER_REG_W +: `OUTER_W];
        end else begin
            // single-channel mode: this set has no effect
            tap1_coeff_o   = {`OUTER_W{1'b0}};
            tap2_coeff_o   = {`OUTER_W{1'b0}};
            tap3_coeff_o   = {`OUTER_W{1'b0}};
            tap4_coeff_o   = {`OUTER_W{1'b0}};
            center_coeff_o = {`CENTER_W{1'b0}};
            tap6_coeff_o   = {`OUTER_W{1'b0}};
            tap7_coeff_o   = {`OUTER_W{1'b0}};
            tap8_coeff_o   = {`OUTER_W{1'b0}};
            tap9_coeff_o   = {`OUTER_W{1'b0}};
        end
    end

endmodule // chan_b_fir_coeff_regs

/* File: verilog/coeff_store.v */
/*
 * nine-entry coefficient store: one synchronous write port, one registered
 * read port and all entries visible in parallel for the filter datapath.
 * assumes: single clock, synchronous active-high reset.
 */
`include "chan_b_coeff_map.vh"

module coeff_store (
    // clock and reset
    input  wire                        clk_i,
    input  wire                        reset_i,
    // write port
    input  wire                        wr_en_i,
    input  wire [`SLOT_W-1:0]          wr_slot_i,
    input  wire [`CENTER_REG_W-1:0]    wr_data_i,
    // read port
    input  wire [`SLOT_W-1:0]          rd_slot_i,
    output reg  [`CENTER_REG_W-1:0]    rd_data_o,
    // all entries, flattened, slot 0 in the low bits
    output wire [`NUM_TAPS*`CENTER_REG_W-1:0] all_o
);

    reg [`CENTER_REG_W-1:0] mem [0:`NUM_TAPS-1];  // storage words
    integer                 i;                    // loop index

    // write and registered read; reset clears every word incl. reserved bits
    always @(posedge clk_i) begin
        if (reset_i) begin
            for (i = 0; i < `NUM_TAPS; i = i + 1) begin
                mem[i] <= `COEFF_RESET;
            end
            rd_data_o <= `COEFF_RESET;
        end else begin
            if (wr_en_i && (wr_slot_i < `NUM_TAPS)) begin
                mem[wr_slot_i] <= wr_data_i;
            end
            if (rd_slot_i < `NUM_TAPS) begin
                rd_data_o <= mem[rd_slot_i];
            end else begin
                rd_data_o <= `COEFF_RESET;
            end
        end
    end

    // parallel view of the words
    genvar g;
    generate
        for (g = 0; g < `NUM_TAPS; g = g + 1) begin : flat
            assign all_o[g*`CENTER_REG_W +: `CENTER_REG_W] = mem[g];
        end
    endgenerate

endmodule // coeff_store
